// ==== incsk_pkg.sv ====
`default_nettype none

package incsk_pkg;

   // ************************************************************
   // opcode layout and codes
   // ************************************************************
   localparam int        ADDR_W     = 7;
   localparam int        DATA_W     = 8;
   localparam logic [1:0] OPC_TOP   = 2'h0;
   localparam logic [3:0] CODE_INC  = 4'ha;
   localparam logic [3:0] CODE_INCS = 4'hf;
   localparam logic      DEST_ACC   = 1'b0;
   localparam logic      DEST_FILE  = 1'b1;

   // ************************************************************
   // data constants
   // ************************************************************
   localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
   localparam logic [DATA_W-1:0] DATA_NULL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_NULL = 7'h00;

   // ************************************************************
   // types
   // ************************************************************
   typedef struct packed {
      logic [1:0]        top;
      logic [3:0]        code;
      logic              dest;
      logic [ADDR_W-1:0] addr;
   } incsk_op_type;

   typedef struct packed {
      logic              file_we;
      logic              acc_we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } incsk_wr_type;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_INC,
      OP_INCS
   } incsk_kind_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_NOP
   } incsk_state_type;

   localparam incsk_op_type OP_RESET = '{top: OPC_TOP, code: 4'h0, dest: DEST_ACC,
                                         addr: ADDR_NULL};
   localparam incsk_wr_type WR_IDLE  = '{file_we: 1'b0, acc_we: 1'b0, addr: ADDR_NULL,
                                         data: DATA_NULL};

   // ************************************************************
   // opcode classification
   // ************************************************************
   function automatic incsk_kind_type incsk_decode(input incsk_op_type op);
      incsk_kind_type kind;
      kind = OP_NONE;
      if (op.top == OPC_TOP && op.code == CODE_INC)
      begin
         kind = OP_INC;
      end
      else if (op.top == OPC_TOP && op.code == CODE_INCS)
      begin
         kind = OP_INCS;
      end
      return kind;
   endfunction

endpackage

`default_nettype wire

// ==== incsk_alu.sv ====
`default_nettype none

module incsk_alu
(
   // operand
   input  wire logic [incsk_pkg::DATA_W-1:0] operand,
   // result
   output logic      [incsk_pkg::DATA_W-1:0] sum,
   output logic                              sum_null
);

   // ************************************************************
   // increment, wrapping at 256
   // ************************************************************
   always_comb
   begin
      sum      = incsk_pkg::DATA_W'(operand + incsk_pkg::DATA_ONE);
      sum_null = (sum == incsk_pkg::DATA_NULL);
   end

endmodule

`default_nettype wire

// ==== incsk_core.sv ====
`default_nettype none

module incsk_core
(
   // clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   // instruction from decode
   input  wire logic                          instr_valid,
   input  wire incsk_pkg::incsk_op_type       instr_word,
   output logic                               instr_ready,
   // file register read port
   output logic      [incsk_pkg::ADDR_W-1:0]  file_rd_addr,
   input  wire logic [incsk_pkg::DATA_W-1:0]  file_rd_data,
   // result write
   output incsk_pkg::incsk_wr_type            wr,
   // zero flag update
   output logic                               zero_we,
   output logic                               zero_val,
   // sequencing toward fetch and program counter
   output logic                               squash_fetched,
   output logic                               nop_slot,
   output logic                               done,
   output logic                               unknown_op
);

   // ************************************************************
   // state
   // ************************************************************
   incsk_pkg::incsk_state_type            state_r,    state_nxt;
   incsk_pkg::incsk_op_type               op_r,       op_nxt;
   incsk_pkg::incsk_kind_type             kind_r,     kind_nxt;
   incsk_pkg::incsk_wr_type               wr_r,       wr_nxt;
   logic [incsk_pkg::ADDR_W-1:0]          rd_addr_r,  rd_addr_nxt;
   logic                                  ready_r,    ready_nxt;
   logic                                  zero_we_r,  zero_we_nxt;
   logic                                  zero_val_r, zero_val_nxt;
   logic                                  squash_r,   squash_nxt;
   logic                                  nop_r,      nop_nxt;
   logic                                  done_r,     done_nxt;
   logic                                  unknown_r,  unknown_nxt;

   incsk_pkg::incsk_kind_type             in_kind;
   logic [incsk_pkg::DATA_W-1:0]          sum;
   logic                                  sum_null;

   // ************************************************************
   // incrementer
   // ************************************************************
   incsk_alu incsk_alu_i
   (
      .operand  (file_rd_data),
      .sum      (sum),
      .sum_null (sum_null)
   );

   // ************************************************************
   // opcode classification, shared by both groups
   // ************************************************************
   assign in_kind = incsk_pkg::incsk_decode(instr_word);

   // ************************************************************
   // sequencing group: next values
   // ************************************************************
   always_comb
   begin
      state_nxt   = state_r;
      op_nxt      = op_r;
      kind_nxt    = kind_r;
      rd_addr_nxt = rd_addr_r;
      case (state_r)
         incsk_pkg::ST_IDLE:
         begin
            // foreign opcodes never leave idle, so ready stays up for them
            if (instr_valid && (in_kind != incsk_pkg::OP_NONE))
            begin
               op_nxt      = instr_word;
               kind_nxt    = in_kind;
               rd_addr_nxt = instr_word.addr;
               state_nxt   = incsk_pkg::ST_EXEC;
            end
         end
         incsk_pkg::ST_EXEC:
         begin
            if ((kind_r == incsk_pkg::OP_INCS) && sum_null)
            begin
               state_nxt = incsk_pkg::ST_NOP;
            end
            else
            begin
               state_nxt = incsk_pkg::ST_IDLE;
            end
         end
         incsk_pkg::ST_NOP:
         begin
            state_nxt = incsk_pkg::ST_IDLE;
         end
         default:
         begin
            state_nxt = incsk_pkg::ST_IDLE;
         end
      endcase
      ready_nxt = (state_nxt == incsk_pkg::ST_IDLE);
   end

   // ************************************************************
   // sequencing group: registers
   // ************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_r   <= incsk_pkg::ST_IDLE;
         op_r      <= incsk_pkg::OP_RESET;
         kind_r    <= incsk_pkg::OP_NONE;
         rd_addr_r <= incsk_pkg::ADDR_NULL;
         ready_r   <= 1'b1;
      end
      else
      begin
         state_r   <= state_nxt;
         op_r      <= op_nxt;
         kind_r    <= kind_nxt;
         rd_addr_r <= rd_addr_nxt;
         ready_r   <= ready_nxt;
      end
   end

   // ************************************************************
   // result group: next values
   // ************************************************************
   always_comb
   begin
      wr_nxt       = incsk_pkg::WR_IDLE;
      zero_we_nxt  = 1'b0;
      zero_val_nxt = zero_val_r;
      squash_nxt   = 1'b0;
      nop_nxt      = 1'b0;
      done_nxt     = 1'b0;
      unknown_nxt  = 1'b0;
      case (state_r)
         incsk_pkg::ST_IDLE:
         begin
            // foreign opcodes belong to other units; flag and stay ready
            unknown_nxt = instr_valid && (in_kind == incsk_pkg::OP_NONE);
         end
         incsk_pkg::ST_EXEC:
         begin
            // read data is combinational from the file, valid this cycle
            wr_nxt.addr    = op_r.addr;
            wr_nxt.data    = sum;
            wr_nxt.file_we = (op_r.dest == incsk_pkg::DEST_FILE);
            wr_nxt.acc_we  = (op_r.dest == incsk_pkg::DEST_ACC);
            if (kind_r == incsk_pkg::OP_INC)
            begin
               zero_we_nxt  = 1'b1;
               zero_val_nxt = sum_null;
               done_nxt     = 1'b1;
            end
            else if (sum_null)
            begin
               // status flags untouched by the skipping form
               squash_nxt = 1'b1;
            end
            else
            begin
               done_nxt = 1'b1;
            end
         end
         incsk_pkg::ST_NOP:
         begin
            // discarded slot costs the second cycle, nothing is written
            nop_nxt  = 1'b1;
            done_nxt = 1'b1;
         end
         default:
         begin
            wr_nxt = incsk_pkg::WR_IDLE;
         end
      endcase
   end

   // ************************************************************
   // result group: registers
   // ************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         wr_r       <= incsk_pkg::WR_IDLE;
         zero_we_r  <= 1'b0;
         zero_val_r <= 1'b0;
         squash_r   <= 1'b0;
         nop_r      <= 1'b0;
         done_r     <= 1'b0;
         unknown_r  <= 1'b0;
      end
      else
      begin
         wr_r       <= wr_nxt;
         zero_we_r  <= zero_we_nxt;
         zero_val_r <= zero_val_nxt;
         squash_r   <= squash_nxt;
         nop_r      <= nop_nxt;
         done_r     <= done_nxt;
         unknown_r  <= unknown_nxt;
      end
   end

   // ************************************************************
   // outputs, all straight from flops
   // ************************************************************
   assign instr_ready    = ready_r;
   assign file_rd_addr   = rd_addr_r;
   assign wr             = wr_r;
   assign zero_we        = zero_we_r;
   assign zero_val       = zero_val_r;
   assign squash_fetched = squash_r;
   assign nop_slot       = nop_r;
   assign done           = done_r;
   assign unknown_op     = unknown_r;

endmodule

`default_nettype wire

// ==== incsk_core_assertions.sv ====
`default_nettype none

module incsk_core_chk
(
   // clock and reset
   input wire logic                    ref_clk,
   input wire logic                    rst,
   // instruction side
   input wire logic                    instr_valid,
   input wire incsk_pkg::incsk_op_type instr_word,
   input wire logic                    instr_ready,
   // file and results
   input wire logic [6:0]              file_rd_addr,
   input wire logic [7:0]              file_rd_data,
   input wire incsk_pkg::incsk_wr_type wr,
   input wire logic                    zero_we,
   input wire logic                    zero_val,
   // sequencing
   input wire logic                    squash_fetched,
   input wire logic                    nop_slot,
   input wire logic                    done,
   input wire logic                    unknown_op
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // taken instructions by kind
   // ************************************************************
   wire go   = instr_valid && instr_ready && instr_word.top == incsk_pkg::OPC_TOP;
   wire g_in = go && instr_word.code == incsk_pkg::CODE_INC;
   wire g_sk = go && instr_word.code == incsk_pkg::CODE_INCS;
   wire g_un = instr_valid && instr_ready && !g_in && !g_sk;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   take_addr_a: assert property (
      (g_in || g_sk) |=> !instr_ready && file_rd_addr == $past(instr_word.addr))
      else $error("read address not taken");
   sum_wrap_a: assert property (
      (g_in || g_sk) ##1 1 |=> wr.data == 8'($past(file_rd_data) + 8'h01))
      else $error("result is not operand plus one");
   dest_sel_a: assert property (
      (g_in || g_sk) |-> ##2 wr.file_we == $past(instr_word.dest, 2)
      && wr.acc_we != $past(instr_word.dest, 2) && wr.addr == $past(instr_word.addr, 2))
      else $error("wrong destination");
   zero_flag_a: assert property (
      g_in |-> ##2 zero_we && done && zero_val == (wr.data == 8'h00))
      else $error("zero flag not updated");
   skip_flags_a: assert property (
      g_sk |-> ##2 !zero_we ##1 !zero_we) else $error("skip form touched flag");
   skip_nop_a: assert property (
      g_sk ##2 wr.data == 8'h00 |-> squash_fetched && !done ##1 nop_slot && done)
      else $error("zero result did not skip");
   no_skip_a: assert property (
      g_sk ##2 wr.data != 8'h00 |-> done && !squash_fetched ##1 !nop_slot)
      else $error("nonzero result skipped");
   unknown_op_a: assert property (g_un |=> unknown_op && instr_ready)
      else $error("unknown opcode not dropped");
   cover property (g_sk ##2 squash_fetched);
   cover property (g_sk ##2 done);
   cover property (g_in ##2 zero_val);
endmodule

bind incsk_core incsk_core_chk incsk_core_chk_i (.ref_clk(ref_clk), .rst(rst),
   .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
   .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data), .wr(wr), .zero_we(zero_we),
   .zero_val(zero_val), .squash_fetched(squash_fetched), .nop_slot(nop_slot),
   .done(done), .unknown_op(unknown_op));

`default_nettype wire

// ==== incsk_regfile.sv ====
`default_nettype none

module incsk_regfile
(
   // clock
   input  wire logic                    ref_clk,
   // read port
   input  wire logic [6:0]              file_rd_addr,
   output logic      [7:0]              file_rd_data,
   // write port
   input  wire incsk_pkg::incsk_wr_type wr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [128];
   // read is combinational: the core samples it in its exec cycle
   assign file_rd_data = mem[file_rd_addr];
   always @(posedge ref_clk)
   begin
      if (wr.file_we)
      begin
         mem[wr.addr] <= wr.data;
      end
   end
endmodule

`default_nettype wire

// ==== increment_and_skip_ops_tb.sv ====
`default_nettype none

`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
   $display("BAD %s exp %h got %h", n, e, g); bad_count++; end end

module increment_and_skip_ops_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                    ref_clk     = 1'b0;
   logic                    rst         = 1'b1;
   logic                    instr_valid = 1'b0;
   incsk_pkg::incsk_op_type instr_word  = incsk_pkg::OP_RESET;
   incsk_pkg::incsk_wr_type wr;
   logic [6:0]              file_rd_addr;
   logic [7:0]              file_rd_data;
   logic                    instr_ready, zero_we, zero_val, squash_fetched, nop_slot;
   logic                    done, unknown_op;
   int                      bad_count = 0;
   int                      n_checks  = 0;
   int                      cyc       = 0;
   always #10 ref_clk = ~ref_clk;
   incsk_core incsk_core_i (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
      .instr_word(instr_word), .instr_ready(instr_ready), .file_rd_addr(file_rd_addr),
      .file_rd_data(file_rd_data), .wr(wr), .zero_we(zero_we), .zero_val(zero_val),
      .squash_fetched(squash_fetched), .nop_slot(nop_slot), .done(done),
      .unknown_op(unknown_op));
   incsk_regfile incsk_regfile_i (.ref_clk(ref_clk), .file_rd_addr(file_rd_addr),
      .file_rd_data(file_rd_data), .wr(wr));
   // ************************************************************
   // one instruction, judged cycle by cycle
   // ************************************************************
   task automatic run_op(input logic [3:0] code, input logic dst, input logic [6:0] a,
                         input logic [7:0] pre);
      logic [7:0] res;
      logic       sk, zi, un;
      res = pre + 8'h01;
      zi  = code == incsk_pkg::CODE_INC;
      un  = !zi && code != incsk_pkg::CODE_INCS;
      sk  = !zi && !un && res == 8'h00;
      incsk_regfile_i.mem[a] = pre;
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr_word  <= '{top: incsk_pkg::OPC_TOP, code: code, dest: dst, addr: a};
      @(posedge ref_clk);
      while (instr_ready !== 1'b1) @(posedge ref_clk);
      instr_valid <= 1'b0;
      // taken at this edge: the first cycle after it shows the exec state
      #1;
      `CHK("unknown", un, unknown_op)
      `CHK("ready", un, instr_ready)
      if (un) return;
      `CHK("rd_addr", a, file_rd_addr)
      @(posedge ref_clk);
      #1;
      `CHK("data", res, wr.data)
      `CHK("file_we", dst, wr.file_we)
      `CHK("acc_we", !dst, wr.acc_we)
      `CHK("zero_we", zi, zero_we)
      if (zi) `CHK("zero_val", res == 8'h00, zero_val)
      `CHK("squash", sk, squash_fetched)
      `CHK("done", !sk, done)
      @(posedge ref_clk);
      #1;
      `CHK("nop", sk, nop_slot)
      `CHK("done2", sk, done)
      `CHK("file", dst ? res : pre, incsk_regfile_i.mem[a])
   endtask
   // wrap to zero into the file, then top address into the accumulator
   task automatic t_inc();
      run_op(incsk_pkg::CODE_INC, 1'b1, 7'h05, 8'hff);
      run_op(incsk_pkg::CODE_INC, 1'b0, 7'h7f, 8'h41);
   endtask
   // zero result skips, one below wrap does not
   task automatic t_skip();
      run_op(incsk_pkg::CODE_INCS, 1'b0, 7'h00, 8'hff);
      run_op(incsk_pkg::CODE_INCS, 1'b1, 7'h10, 8'hfe);
      run_op(incsk_pkg::CODE_INCS, 1'b1, 7'h33, 8'hff);
   endtask
   task automatic t_unknown();
      run_op(4'h9, 1'b1, 7'h20, 8'h00);
   endtask
   task automatic test_done();
      $display("checks %0d bad %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard, far above the few dozen cycles the tests need
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         bad_count++;
         test_done();
      end
   end
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_inc();
      t_skip();
      t_unknown();
      test_done();
   end
endmodule

`default_nettype wire
